// [src/comparator_defines.svh]
// Register offsets, field positions, reset values and timing counts of the comparator control block
`ifndef COMPARATOR_DEFINES_SVH
`define COMPARATOR_DEFINES_SVH

`define ADDR_W                 3
`define OFF_CONTROL            3'h0
`define OFF_WINDOW_CONFIG      3'h1
`define OFF_INPUT_SELECT       3'h2
`define OFF_THRESHOLD_LEVEL    3'h5
`define OFF_INTERRUPT_CONFIG   3'h6
`define OFF_STATUS             3'h7

`define RST_CONTROL            8'h00
`define RST_WINDOW_CONFIG      8'h00
`define RST_INPUT_SELECT       8'h00
`define RST_THRESHOLD_LEVEL    8'hFF
`define RST_INTERRUPT_CONFIG   8'h00

`define BIT_ENABLE             0
`define BIT_INVERT             7
`define BIT_INIT_VALUE         6
`define POSSEL_HI              5
`define POSSEL_LO              3
`define NEGSEL_HI              2
`define NEGSEL_LO              0
`define TRIG_HI                5
`define TRIG_LO                4
`define BIT_IRQ_EN             0
`define WINPOS_HI              7
`define WINPOS_LO              6
`define BIT_LEVEL_STATE        4
`define BIT_IRQ_FLAG           0

`define PARTNER_SEL_OFF        2'h0
`define PARTNER_SEL_NEXT       2'h1
`define POS_MAX_CODE           3'h4
`define NEG_DIVIDER_CODE       3'h4
`define THRESHOLD_DENOM        256

`define SETTLE_TIME_NS         1000
`define CLK_PERIOD_NS          10
`define SETTLE_CYCLES          ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/comparator_pkg.sv]
// Types shared by the comparator control block
package comparator_pkg;

  typedef enum logic [1:0] {
    WPOS_ABOVE  = 2'h0,
    WPOS_INSIDE = 2'h1,
    WPOS_BELOW  = 2'h2
  } window_pos_t;

  typedef enum logic [1:0] {
    TRIG_ANY_OR_ABOVE = 2'h0,
    TRIG_INSIDE       = 2'h1,
    TRIG_FALL_BELOW   = 2'h2,
    TRIG_RISE_OUTSIDE = 2'h3
  } trigger_t;

  typedef struct packed {
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic [7:0] threshold;
    logic       enable;
  } analog_cfg_t;

endpackage : comparator_pkg

// [src/level_sync.sv]
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module level_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // First flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync

`default_nettype wire

// [src/comparator_window_control.sv]
// Control, status and interrupt logic around one analog voltage comparator
`timescale 1ns/100ps
`default_nettype none
`include "comparator_defines.svh"

module comparator_window_control
  import comparator_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic              cmp_raw,
  input  wire logic              partner_raw,
  output var analog_cfg_t        analog_cfg,
  output logic                   partner_pair,
  output logic                   cmp_out,
  output logic                   irq
);

  logic [7:0]  control_r;
  logic [1:0]  window_partner_select_r;
  logic [7:0]  input_select_r;
  logic [7:0]  threshold_level_r;
  logic [7:0]  interrupt_config_r;
  logic        irq_flag_r;
  logic [SETTLE_CYCLES > 1 ? $clog2(SETTLE_CYCLES+1)-1 : 0 : 0] settle_cnt_r;
  logic        ready_r;
  logic        result_r;
  logic        result_prev_r;
  logic        winpos_valid_r;
  window_pos_t winpos_prev_r;
  logic        level_s1_r;
  logic        level_s2_r;
  logic [7:0]  control_nxt;
  logic [1:0]  window_select_nxt;
  logic [7:0]  input_select_nxt;
  logic [7:0]  threshold_level_nxt;
  logic [7:0]  interrupt_config_nxt;
  logic        irq_flag_nxt;

  logic        cmp_sync;
  logic        partner_sync;
  logic        enable;
  logic        window_on;
  logic        inverted;
  logic        result_nxt;
  logic        level_nxt;
  logic        hit;
  logic        clear_req;
  window_pos_t winpos;
  trigger_t    trig;
  logic        output_initial_value;
  logic        invert_output;

  // Analog outputs are asynchronous to clk; resample before use
  level_sync u_cmp_sync
  (
    .clk      (clk),
    .reset    (reset),
    .async_in (cmp_raw),
    .sync_out (cmp_sync)
  );

  level_sync u_partner_sync
  (
    .clk      (clk),
    .reset    (reset),
    .async_in (partner_raw),
    .sync_out (partner_sync)
  );

  assign enable    = control_r[`BIT_ENABLE];
  assign window_on = (window_partner_select_r == `PARTNER_SEL_NEXT);
  assign trig      = trigger_t'(interrupt_config_r[`TRIG_HI:`TRIG_LO]);
  assign clear_req = wr && (addr == `OFF_STATUS) && wdata[`BIT_IRQ_FLAG];

  // This unit is the upper limit, the partner the lower limit of the window
  always_comb
  begin
    if (cmp_sync)
      winpos = WPOS_ABOVE;
    else if (partner_sync)
      winpos = WPOS_INSIDE;
    else
      winpos = WPOS_BELOW;
  end

  assign output_initial_value = input_select_r[`BIT_INIT_VALUE];
  assign invert_output        = input_select_r[`BIT_INVERT];
  assign inverted             = cmp_sync ^ invert_output;

  // Result and level state before synchronisation into status
  always_comb
  begin
    result_nxt = inverted;
    if (!ready_r)
      result_nxt = output_initial_value;
    level_nxt = result_nxt;
    if (window_on && ready_r)
    begin
      case (trig)
        TRIG_ANY_OR_ABOVE: level_nxt = (winpos == WPOS_ABOVE);
        TRIG_INSIDE:       level_nxt = (winpos == WPOS_INSIDE);
        TRIG_FALL_BELOW:   level_nxt = (winpos == WPOS_BELOW);
        TRIG_RISE_OUTSIDE: level_nxt = (winpos != WPOS_INSIDE);
        default:           level_nxt = 1'b0;
      endcase
    end
  end

  // Trigger detection on entering a window state or on a result edge
  always_comb
  begin
    hit = 1'b0;
    if (ready_r && window_on)
    begin
      if (winpos_valid_r && (winpos != winpos_prev_r))
      begin
        case (trig)
          TRIG_ANY_OR_ABOVE: hit = (winpos == WPOS_ABOVE);
          TRIG_INSIDE:       hit = (winpos == WPOS_INSIDE);
          TRIG_FALL_BELOW:   hit = (winpos == WPOS_BELOW);
          TRIG_RISE_OUTSIDE: hit = (winpos != WPOS_INSIDE) && (winpos_prev_r == WPOS_INSIDE);
          default:           hit = 1'b0;
        endcase
      end
    end
    else if (ready_r)
    begin
      case (trig)
        TRIG_ANY_OR_ABOVE: hit = (result_nxt != result_prev_r);
        TRIG_FALL_BELOW:   hit = result_prev_r && !result_nxt;
        TRIG_RISE_OUTSIDE: hit = !result_prev_r && result_nxt;
        default:           hit = 1'b0;
      endcase
    end
  end

  // Register next values; outputs load from these so a write reaches the pins on the same edge as the register
  always_comb
  begin
    control_nxt          = control_r;
    window_select_nxt    = window_partner_select_r;
    input_select_nxt     = input_select_r;
    threshold_level_nxt  = threshold_level_r;
    interrupt_config_nxt = interrupt_config_r;
    if (wr)
    begin
      case (addr)
        `OFF_CONTROL:          control_nxt = wdata;
        `OFF_WINDOW_CONFIG:    window_select_nxt = wdata[1:0];
        `OFF_INPUT_SELECT:     input_select_nxt = wdata;
        `OFF_THRESHOLD_LEVEL:  threshold_level_nxt = wdata;
        // Unused bits are dropped so they read back as zero
        `OFF_INTERRUPT_CONFIG: interrupt_config_nxt = {2'h0, wdata[5:4], 3'h0, wdata[0]};
        default:               ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      control_r <= `RST_CONTROL;
    else
      control_r <= control_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      window_partner_select_r <= `PARTNER_SEL_OFF;
    else
      window_partner_select_r <= window_select_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      input_select_r <= `RST_INPUT_SELECT;
    else
      input_select_r <= input_select_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      threshold_level_r <= `RST_THRESHOLD_LEVEL;
    else
      threshold_level_r <= threshold_level_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      interrupt_config_r <= `RST_INTERRUPT_CONFIG;
    else
      interrupt_config_r <= interrupt_config_nxt;
  end

  // Settling counter: the analog core is trusted only after it is enabled long enough
  always_ff @(posedge clk)
  begin
    if (reset || !enable)
    begin
      settle_cnt_r <= '0;
      ready_r      <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (int'(settle_cnt_r) >= SETTLE_CYCLES - 1)
        ready_r <= 1'b1;
      else
        settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  // Result and history for edge and window detection
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result_r       <= 1'b0;
      result_prev_r  <= 1'b0;
      winpos_valid_r <= 1'b0;
      winpos_prev_r  <= WPOS_ABOVE;
    end
    else
    begin
      result_r       <= result_nxt;
      result_prev_r  <= result_nxt;
      winpos_valid_r <= ready_r && window_on;
      winpos_prev_r  <= winpos;
    end
  end

  // Level state reaches status one flop after the result stage, two flops in all
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      level_s1_r <= 1'b0;
      level_s2_r <= 1'b0;
    end
    else
    begin
      level_s1_r <= level_nxt;
      level_s2_r <= level_s1_r;
    end
  end

  // Sticky flag as it stands after this edge; a new hit beats a clear in the same cycle
  always_comb
  begin
    irq_flag_nxt = irq_flag_r;
    if (hit)
      irq_flag_nxt = 1'b1;
    else if (clear_req)
      irq_flag_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_flag_r <= 1'b0;
    else
      irq_flag_r <= irq_flag_nxt;
  end

  // Built from next values so the request never lags a clear or a mask write
  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= interrupt_config_nxt[`BIT_IRQ_EN] && irq_flag_nxt;
  end

  // Outputs to analog core and neighbour
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      analog_cfg   <= '{pos_sel: 3'h0, neg_sel: 3'h0, threshold: `RST_THRESHOLD_LEVEL, enable: 1'b0};
      partner_pair <= 1'b0;
      cmp_out      <= 1'b0;
    end
    else
    begin
      analog_cfg.pos_sel   <= input_select_nxt[`POSSEL_HI:`POSSEL_LO];
      analog_cfg.neg_sel   <= input_select_nxt[`NEGSEL_HI:`NEGSEL_LO];
      analog_cfg.threshold <= threshold_level_nxt;
      analog_cfg.enable    <= control_nxt[`BIT_ENABLE];
      partner_pair         <= (window_select_nxt == `PARTNER_SEL_NEXT);
      cmp_out              <= result_nxt;
    end
  end

  // Read data one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `OFF_CONTROL:          rdata <= control_r;
        `OFF_WINDOW_CONFIG:    rdata <= {6'h00, window_partner_select_r};
        `OFF_INPUT_SELECT:     rdata <= input_select_r;
        `OFF_THRESHOLD_LEVEL:  rdata <= threshold_level_r;
        `OFF_INTERRUPT_CONFIG: rdata <= interrupt_config_r;
        `OFF_STATUS:           rdata <= {(window_on ? winpos : WPOS_ABOVE), 1'b0, level_s2_r,
                                         3'h0, irq_flag_r};
        default:               rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule : comparator_window_control

`default_nettype wire

// [testbench/comparator_properties.sv]
// Port-level assertions for the comparator control block
`timescale 1ns/100ps
`default_nettype none
`include "comparator_defines.svh"
module comparator_properties
  import comparator_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0]         wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [7:0]         rdata,
  input wire analog_cfg_t        analog_cfg,
  input wire logic               partner_pair,
  input wire logic               cmp_out,
  input wire logic               irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  pair_sel_a: assert property (wr && addr == 3'h1 |=> partner_pair == ($past(wdata[1:0]) == 2'h1))
    else $error("pairing select wrong");
  mux_sel_a: assert property (wr && addr == 3'h2 |=>
    {analog_cfg.pos_sel, analog_cfg.neg_sel} == $past(wdata[5:0]))
    else $error("input select wrong");
  thresh_val_a: assert property (wr && addr == 3'h5 |=> analog_cfg.threshold == $past(wdata))
    else $error("threshold wrong");
  enable_bit_a: assert property (wr && addr == 3'h0 |=> analog_cfg.enable == $past(wdata[0]))
    else $error("enable wrong");
  irq_hold_a: assert property (irq && !wr |=> irq)
    else $error("request dropped without write");
  irq_mask_a: assert property (wr && addr == 3'h6 && !wdata[0] |=> !irq)
    else $error("masked request high");
  gap_read_a: assert property (rd && (addr == 3'h3 || addr == 3'h4) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  level_sync_a: assert property ($stable({cmp_out, partner_pair})[*4] ##0
    (rd && addr == 3'h7 && !partner_pair) |=> rdata[4] == $past(cmp_out))
    else $error("level state differs from result");

  cover property ($rose(irq));
  cover property ($rose(cmp_out));
  cover property (partner_pair && rd && addr == 3'h7);
endmodule : comparator_properties

bind comparator_window_control comparator_properties props_inst
(
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .analog_cfg(analog_cfg), .partner_pair(partner_pair), .cmp_out(cmp_out), .irq(irq)
);
`default_nettype wire

// [testbench/analog_core_model.sv]
// Behavioural comparator pair facing the control block
`timescale 1ns/100ps
`default_nettype none
module analog_core_model
  import comparator_pkg::*;
#(
  parameter logic [7:0] LOWER_REF = 8'h40
)
(
  input  wire analog_cfg_t     analog_cfg,
  input  wire logic            clk,
  input  wire logic [4:0][7:0] vpos,
  input  wire logic [3:0][7:0] vneg,
  output logic                 cmp_raw,
  output logic                 partner_raw
);
  logic [7:0] vin;
  logic [7:0] vref;
  // Reserved positive codes read as ground; reserved negative codes fold onto vneg by their low two bits
  assign vin  = analog_cfg.pos_sel <= 3'h4 ? vpos[analog_cfg.pos_sel] : 8'h00;
  assign vref = analog_cfg.neg_sel == 3'h4 ? analog_cfg.threshold : vneg[analog_cfg.neg_sel[1:0]];
  // A disabled core idles low; one cycle stands in for analog delay
  always_ff @(posedge clk)
  begin
    cmp_raw     <= analog_cfg.enable && vin > vref;
    partner_raw <= analog_cfg.enable && vin > LOWER_REF;
  end
endmodule : analog_core_model
`default_nettype wire

// [testbench/comparator_window_control_test.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module comparator_window_control_test;
  import comparator_pkg::*;
  localparam logic [7:0] UPPER = 8'hC0;
  logic            clk, reset, wr, rd, cmp_raw, partner_raw, partner_pair, cmp_out, irq, exp_flag;
  logic [2:0]      addr;
  logic [7:0]      wdata, rdata, v;
  logic [1:0]      q;
  logic [4:0][7:0] vpos;
  analog_cfg_t     analog_cfg;
  int              mismatches, num_checks, seed, t, p;

  comparator_window_control #(.SETTLE_CYCLES(2)) comparator_window_control_inst
  (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_raw(cmp_raw), .partner_raw(partner_raw), .analog_cfg(analog_cfg),
    .partner_pair(partner_pair), .cmp_out(cmp_out), .irq(irq)
  );
  analog_core_model analog_core_model_inst
  (
    .analog_cfg(analog_cfg), .clk(clk), .vpos(vpos), .vneg({4{8'h80}}),
    .cmp_raw(cmp_raw), .partner_raw(partner_raw)
  );

  function automatic logic [1:0] wpos(input logic [7:0] x);
    return x > UPPER ? 2'h0 : (x > 8'h40 ? 2'h1 : 2'h2);
  endfunction : wpos
  // Outside matches both above and below
  function automatic logic wmatch(input logic [1:0] tr, input logic [1:0] ps);
    return tr == 2'h3 ? ps != 2'h1 : ps == tr;
  endfunction : wmatch

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rreg
  // Generous fixed wait covers model, synchroniser and status lag
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask : settle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test;
  end

  initial
  begin
    seed = 32'h2087;
    {reset, wr, rd, addr, wdata, vpos} = {1'b1, 13'h0, 40'h0};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (t = 0; t < 8; t++)
      rreg(t[2:0], t == 5 ? 8'hFF : 8'h00);
    repeat (6)
    begin
      v = 8'($random(seed));
      wreg(3'h5, v);
      rreg(3'h5, v);
      wreg(3'h6, v);
      rreg(3'h6, v & 8'h31);
      wreg(3'h1, v);
      chk(partner_pair, v[1:0] == 2'h1);
      wreg(3'h2, v & 8'hDB);
      rreg(3'h2, v & 8'hDB);
    end
    wreg(3'h1, 8'h00);
    wreg(3'h5, UPPER);
    wreg(3'h2, 8'h04);
    wreg(3'h0, 8'h01);
    for (t = 0; t < 4; t++)
    begin
      if (t == 1)
        continue;
      wreg(3'h6, {2'h0, t[1:0], 4'h1});
      vpos[0] <= 8'h10;
      settle;
      wreg(3'h7, 8'h01);
      vpos[0] <= 8'hF0;
      settle;
      chk(irq, t != 2);
      wreg(3'h7, 8'h00);
      rreg(3'h7, {7'h08, t != 2});
      wreg(3'h7, 8'h01);
      vpos[0] <= 8'h10;
      settle;
      wreg(3'h6, {2'h0, t[1:0], 4'h0});
      chk(irq, 1'b0);
      rreg(3'h7, {7'h00, t != 3});
    end
    wreg(3'h7, 8'h01);
    wreg(3'h2, 8'h84);
    settle;
    chk(cmp_out, 1'b1);
    rreg(3'h7, 8'h11);
    wreg(3'h0, 8'h00);
    wreg(3'h2, 8'h44);
    settle;
    chk(cmp_out, 1'b1);
    wreg(3'h2, 8'h84);
    settle;
    chk(cmp_out, 1'b0);
    wreg(3'h2, 8'h04);
    wreg(3'h0, 8'h01);
    wreg(3'h1, 8'h01);
    q = 2'h2;
    for (t = 0; t < 14; t++)
    begin
      v = t == 0 ? 8'hC1 : (t == 1 ? 8'hC0 : (t == 2 ? 8'h40 : 8'($random(seed))));
      p = $random(seed);
      wreg(3'h6, {2'h0, p[1:0], 4'h1});
      settle;
      wreg(3'h7, 8'h01);
      vpos[0] <= v;
      settle;
      exp_flag = wmatch(p[1:0], wpos(v)) && !wmatch(p[1:0], q);
      chk(irq, exp_flag);
      rreg(3'h7, {wpos(v), 1'b0, wmatch(p[1:0], wpos(v)), 3'h0, exp_flag});
      q = wpos(v);
    end
    finish_test;
  end
endmodule : comparator_window_control_test
`default_nettype wire
